/* verilog/ptr_pkg.sv */
/*
 * Shared constants and carrier types of the PCIe target responder.
 * Assumes the endpoint core delivers only requests that already matched
 * one of its BARs, with the match vector in the receive user sideband.
 */
package ptr_pkg;

   // Receive user sideband width and position of the BAR match vector.
   localparam int RX_USER_W   = 22;
   localparam int BAR_HIT_LSB = 2;
   localparam int BAR_HIT_W   = 8;

   // Match vector bits that steer a request to a region.
   localparam int HIT_IO    = 0;
   localparam int HIT_MEM64 = 1;
   localparam int HIT_MEM32 = 2;
   localparam int HIT_EROM  = 6;

   // Region numbers inside the target memory.
   localparam logic [1:0] REG_IO     = 2'h0;
   localparam logic [1:0] REG_NARROW = 2'h1;
   localparam logic [1:0] REG_WIDE   = 2'h2;
   localparam logic [1:0] REG_ROM    = 2'h3;

   // Each region holds 2 KB, that is 512 words.
   localparam int REGION_AW = 9;
   localparam int MEM_WORDS = 2048;

   // Packet format and type codes.
   localparam logic [1:0] FMT_3DW_ND = 2'h0;
   localparam logic [1:0] FMT_3DW_D  = 2'h2;
   localparam logic [4:0] TYPE_MEM   = 5'h00;
   localparam logic [4:0] TYPE_IO    = 5'h02;
   localparam logic [4:0] TYPE_CPL   = 5'h0A;

   // Completion fields and request length of one word.
   localparam logic [9:0]  LEN_ONE   = 10'h001;
   localparam logic [11:0] CPL_BYTES = 12'h004;
   localparam logic [2:0]  CPL_OK    = 3'h0;

   // Number of header and data words kept from a request.
   localparam int HDR_DW = 5;

   // Reset value of the receive ready output.
   localparam logic READY_RST = 1'b1;

   // Everything the block keeps about one accepted request.
   typedef struct packed {
      logic        is_wr;
      logic [2:0]  tc;
      logic        td;
      logic        ep;
      logic [1:0]  attr;
      logic [15:0] rid;
      logic [7:0]  tag;
      logic [3:0]  be;
      logic [1:0]  region;
      logic [10:0] addr;
      logic [31:0] data;
   } ptr_req_t;

   // Receive and service sequence.
   typedef enum logic [2:0] {
      ST_RECV, ST_DECODE, ST_WRITE, ST_WDONE, ST_READ, ST_BUILD, ST_WAIT
   } ptr_state_t;

endpackage

/* verilog/ptr_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; DEPTH is a power of two.
 */
`timescale 1ns/10ps
module ptr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];   // Storage entries.
   logic [AW:0]      wr_q;            // Write pointer with wrap bit.
   logic [AW:0]      rd_q;            // Read pointer with wrap bit.
   logic             push;            // An entry is written.
   logic             pop;             // An entry is taken.

   // Full when pointers differ only in the wrap bit, empty when equal.
   assign in_ready  = (wr_q != {~rd_q[AW], rd_q[AW-1:0]});
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem_q[rd_q[AW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Entries are written at the write pointer.
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // Pointers advance on each accepted push and pop.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule

/* verilog/ptr_target.sv */
/*
 * Target-only responder behind a PCIe endpoint core: four 2 KB regions,
 * single-word memory and I/O reads and writes, completions, turn-off.
 * Assumes the core's user clock and reset, and that the core forwards
 * only BAR-matched requests with the match vector in rx tuser[9:2].
 */
// Functional notes
// - I/O write gets no-data completion only.
// - Write: take address, data, region, then write.
// - Match bit 0 selects I/O region.
// - Match bit 2 selects narrow memory region.
// - Ready low until write finishes.
// - Ready low until read completion generated.
// - Every single-word read that passes req_ok returns a completion with data.
// - Read: take address, region, then read.
// - Stream width 32, 64 or 128 bits.
// - Wide variant only on fast cores.
// - Acknowledge every power turn-off request.
// - Attach to stream and configuration interfaces.
// - Longer requests accepted whole, then dropped.
// - Next read waits for completion sent.
// - Next write waits for write pending drop.
`timescale 1ns/10ps
module ptr_target #(
   parameter int DATA_W     = 64,   // Stream width of the attached core.
   parameter int LINK_LANES = 8,    // Lane count of the attached core.
   parameter int LINK_MBPS  = 5000, // Lane rate of the attached core.
   parameter int FIFO_DEPTH = 16    // Completion beats held.
) (
   input  wire logic                           core_clk,
   input  wire logic                           resetn,
   input  wire logic [DATA_W-1:0]              m_axis_rx_tdata,
   input  wire logic [DATA_W/8-1:0]            m_axis_rx_tkeep,
   input  wire logic                           m_axis_rx_tlast,
   input  wire logic                           m_axis_rx_tvalid,
   input  wire logic [ptr_pkg::RX_USER_W-1:0]  m_axis_rx_tuser,
   output logic                                m_axis_rx_tready,
   output logic [DATA_W-1:0]                   s_axis_tx_tdata,
   output logic [DATA_W/8-1:0]                 s_axis_tx_tkeep,
   output logic                                s_axis_tx_tlast,
   output logic                                s_axis_tx_tvalid,
   input  wire logic                           s_axis_tx_tready,
   input  wire logic [15:0]                    cfg_completer_id,
   input  wire logic                           cfg_to_turnoff,
   output logic                                cfg_turnoff_ok
);
   // Words per beat and FIFO entry width.
   localparam int L  = DATA_W / 32;
   localparam int KW = DATA_W / 8;
   localparam int FW = DATA_W + KW + 1;

   // The wide variant only exists for x8 at either rate or x4 at 5 Gb/s.
   localparam bit VARIANT_OK = (DATA_W == 32) || (DATA_W == 64) ||
      ((DATA_W == 128) && ((LINK_LANES == 8) ||
      ((LINK_LANES == 4) && (LINK_MBPS == 5000))));

   ptr_pkg::ptr_state_t state_q;     // Current step of the sequence.
   ptr_pkg::ptr_state_t state_d;     // Next step of the sequence.
   ptr_pkg::ptr_req_t   req_q;       // Request under service.
   ptr_pkg::ptr_req_t   req_d;       // Request as decoded from header.

   logic [31:0] hdr_q [ptr_pkg::HDR_DW];  // Collected header and data words.
   logic [2:0]  cnt_q;               // Words collected in this packet.
   logic [7:0]  hit_q;               // BAR match vector of the packet.
   logic        take;                // A receive beat is accepted.
   logic        req_ok;              // Request is one supported by the block.

   logic [31:0] mem_q [ptr_pkg::MEM_WORDS];  // The four target regions.
   logic [10:0] mem_idx;             // Region and word index of request.
   logic [31:0] rd_data_q;           // Word read for a completion.
   logic        wr_busy_q;           // Memory write still pending.

   logic [2:0]  beat_q;              // Completion beat being queued.
   logic [31:0] cpl_dw [4];          // Completion words.
   logic [2:0]  cpl_n;               // Completion word count.
   logic [FW-1:0] beat_data;         // Beat offered to the FIFO.
   logic        beat_last;           // This beat ends the completion.
   logic        f_in_valid;          // FIFO fill strobe.
   logic        f_in_ready;          // FIFO has room.
   logic        f_out_valid;         // FIFO holds a beat.
   logic        f_out_ready;         // Output stage takes a beat.
   logic [FW-1:0] f_out_data;        // Beat leaving the FIFO.
   logic        compl_done_q;        // Completion fully sent, one cycle.

   assign take = m_axis_rx_tvalid & m_axis_rx_tready;

   // Capture words of the packet; words past the fifth are dropped.
   for (genvar i = 0; i < ptr_pkg::HDR_DW; i++) begin : g_hdr
      always_ff @(posedge core_clk or negedge resetn) begin
         if (!resetn) begin
            hdr_q[i] <= 32'h0000_0000;
         end else if (take && (i >= int'(cnt_q)) && (i < int'(cnt_q) + L)) begin
            hdr_q[i] <= m_axis_rx_tdata[32*(i-int'(cnt_q)) +: 32];
         end
      end
   end

   // Count collected words, saturating, restarting at packet end.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 3'h0;
      end else if (take) begin
         if (m_axis_rx_tlast) begin
            cnt_q <= 3'h0;
         end else if (int'(cnt_q) + L > 7) begin
            cnt_q <= 3'h7;
         end else begin
            cnt_q <= cnt_q + 3'(L);
         end
      end
   end

   // The match vector is sampled on the first beat of each packet.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hit_q <= 8'h00;
      end else if (take && (cnt_q == 3'h0)) begin
         hit_q <= m_axis_rx_tuser[ptr_pkg::BAR_HIT_LSB +: ptr_pkg::BAR_HIT_W];
      end
   end

   // Decode the collected packet into a request.
   always_comb begin
      logic [1:0]  fmt;
      logic [4:0]  typ;
      logic [31:0] adw;
      fmt = hdr_q[0][30:29];
      typ = hdr_q[0][28:24];
      adw = fmt[0] ? hdr_q[3] : hdr_q[2];
      req_d.is_wr = fmt[1];
      req_d.tc    = hdr_q[0][22:20];
      req_d.td    = hdr_q[0][15];
      req_d.ep    = hdr_q[0][14];
      req_d.attr  = hdr_q[0][13:12];
      req_d.rid   = hdr_q[1][31:16];
      req_d.tag   = hdr_q[1][15:8];
      req_d.be    = hdr_q[1][3:0];
      req_d.addr  = adw[10:0];
      req_d.data  = fmt[0] ? hdr_q[4] : hdr_q[3];
      // Regions follow the core's default match patterns.
      if (hit_q[ptr_pkg::HIT_IO]) begin
         req_d.region = ptr_pkg::REG_IO;
      end else if (hit_q[ptr_pkg::HIT_MEM32]) begin
         req_d.region = ptr_pkg::REG_NARROW;
      end else if (hit_q[ptr_pkg::HIT_MEM64]) begin
         req_d.region = ptr_pkg::REG_WIDE;
      end else begin
         req_d.region = ptr_pkg::REG_ROM;
      end
      // Only single-word memory and I/O requests with a hit are served.
      req_ok = (hdr_q[0][9:0] == ptr_pkg::LEN_ONE) &&
               ((typ == ptr_pkg::TYPE_MEM) || (typ == ptr_pkg::TYPE_IO)) &&
               ((hit_q & 8'h47) != 8'h00);
   end

   // Sequence: collect, decode, write or read, queue completion, wait.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ptr_pkg::ST_RECV: begin
            if (take && m_axis_rx_tlast) begin
               state_d = ptr_pkg::ST_DECODE;
            end
         end
         ptr_pkg::ST_DECODE: begin
            if (!req_ok) begin
               state_d = ptr_pkg::ST_RECV;
            end else if (req_d.is_wr) begin
               state_d = ptr_pkg::ST_WRITE;
            end else begin
               state_d = ptr_pkg::ST_READ;
            end
         end
         ptr_pkg::ST_WRITE: begin
            state_d = ptr_pkg::ST_WDONE;
         end
         ptr_pkg::ST_WDONE: begin
            if (!wr_busy_q) begin
               // I/O writes need a completion, memory writes do not.
               if (req_q.region == ptr_pkg::REG_IO) begin
                  state_d = ptr_pkg::ST_BUILD;
               end else begin
                  state_d = ptr_pkg::ST_RECV;
               end
            end
         end
         ptr_pkg::ST_READ: begin
            state_d = ptr_pkg::ST_BUILD;
         end
         ptr_pkg::ST_BUILD: begin
            if (f_in_ready && beat_last) begin
               state_d = ptr_pkg::ST_WAIT;
            end
         end
         ptr_pkg::ST_WAIT: begin
            if (compl_done_q) begin
               state_d = ptr_pkg::ST_RECV;
            end
         end
      endcase
   end

   // State register; reset returns to collecting requests.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ptr_pkg::ST_RECV;
      end else begin
         state_q <= state_d;
      end
   end

   // Ready is high only while collecting, low during any service.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         m_axis_rx_tready <= ptr_pkg::READY_RST & VARIANT_OK;
      end else begin
         m_axis_rx_tready <= (state_d == ptr_pkg::ST_RECV) && VARIANT_OK;
      end
   end

   // The decoded request is held for the whole service.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         req_q <= '0;
      end else if (state_q == ptr_pkg::ST_DECODE) begin
         req_q <= req_d;
      end
   end

   assign mem_idx = {req_q.region, req_q.addr[ptr_pkg::REGION_AW+1:2]};

   // Byte-enabled write into the selected region, one cycle long.
   always_ff @(posedge core_clk) begin
      if (state_q == ptr_pkg::ST_WRITE) begin
         for (int b = 0; b < 4; b++) begin
            if (req_q.be[b]) begin
               mem_q[mem_idx][8*b +: 8] <= req_q.data[8*b +: 8];
            end
         end
      end
   end

   // Write pending: raised by the write and dropped one cycle after.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wr_busy_q <= 1'b0;
      end else begin
         wr_busy_q <= (state_q == ptr_pkg::ST_WRITE);
      end
   end

   // Read of the selected region for the completion data.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data_q <= 32'h0000_0000;
      end else if (state_q == ptr_pkg::ST_READ) begin
         rd_data_q <= mem_q[mem_idx];
      end
   end

   // Completion words: header, then data for reads only.
   always_comb begin
      logic       dat;
      logic [1:0] low;
      low = 2'h0;
      dat = !req_q.is_wr;
      casez (req_q.be)
         4'b???1: low = 2'h0;
         4'b??10: low = 2'h1;
         4'b?100: low = 2'h2;
         4'b1000: low = 2'h3;
      endcase
      cpl_dw[0] = {1'b0, dat ? ptr_pkg::FMT_3DW_D : ptr_pkg::FMT_3DW_ND,
                   ptr_pkg::TYPE_CPL, 1'b0, req_q.tc, 4'h0, req_q.td,
                   req_q.ep, req_q.attr, 2'h0,
                   dat ? ptr_pkg::LEN_ONE : 10'h000};
      cpl_dw[1] = {cfg_completer_id, ptr_pkg::CPL_OK, 1'b0,
                   ptr_pkg::CPL_BYTES};
      cpl_dw[2] = {req_q.rid, req_q.tag, 1'b0, req_q.addr[6:2], low};
      cpl_dw[3] = rd_data_q;
      cpl_n     = dat ? 3'h4 : 3'h3;
   end

   // Pack the current completion beat as last, keep and data.
   always_comb begin
      int idx;
      idx = 0;
      beat_data = '0;
      for (int k = 0; k < L; k++) begin
         idx = int'(beat_q) * L + k;
         if (idx < int'(cpl_n)) begin
            beat_data[32*k +: 32]        = cpl_dw[idx];
            beat_data[DATA_W+4*k +: 4]   = 4'hF;
         end
      end
      beat_last = (int'(beat_q) + 1) * L >= int'(cpl_n);
      beat_data[FW-1] = beat_last;
   end

   assign f_in_valid = (state_q == ptr_pkg::ST_BUILD);

   // Beat counter advances as the FIFO accepts completion beats.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         beat_q <= 3'h0;
      end else if (state_q != ptr_pkg::ST_BUILD) begin
         beat_q <= 3'h0;
      end else if (f_in_ready) begin
         beat_q <= beat_q + 3'h1;
      end
   end

   // Completion beats wait here while the transmit side stalls.
   ptr_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   (beat_data),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   assign f_out_ready = !s_axis_tx_tvalid || s_axis_tx_tready;

   // Transmit output stage, refilled whenever it empties or drains.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s_axis_tx_tvalid <= 1'b0;
         s_axis_tx_tdata  <= '0;
         s_axis_tx_tkeep  <= '0;
         s_axis_tx_tlast  <= 1'b0;
      end else if (f_out_ready) begin
         s_axis_tx_tvalid <= f_out_valid;
         s_axis_tx_tdata  <= f_out_data[DATA_W-1:0];
         s_axis_tx_tkeep  <= f_out_data[DATA_W +: KW];
         s_axis_tx_tlast  <= f_out_data[FW-1];
      end
   end

   // Completion sent: the last beat was taken by the core.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         compl_done_q <= 1'b0;
      end else begin
         compl_done_q <= s_axis_tx_tvalid && s_axis_tx_tready &&
                         s_axis_tx_tlast;
      end
   end

   // Turn-off is granted once no request is in flight or queued.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_turnoff_ok <= 1'b0;
      end else begin
         cfg_turnoff_ok <= cfg_to_turnoff &&
                           (state_q == ptr_pkg::ST_RECV) &&
                           (cnt_q == 3'h0) && !f_out_valid &&
                           !s_axis_tx_tvalid;
      end
   end

endmodule

/* dv/ptr_target_props.sv */
/*
 * Port checker for the target responder, bound into ptr_target.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
`timescale 1ns/10ps
module ptr_target_props #(
   parameter int DATA_W = 64
) (
   input wire logic              core_clk,
   input wire logic              resetn,
   input wire logic              m_axis_rx_tvalid,
   input wire logic              m_axis_rx_tlast,
   input wire logic              m_axis_rx_tready,
   input wire logic [DATA_W-1:0] s_axis_tx_tdata,
   input wire logic              s_axis_tx_tlast,
   input wire logic              s_axis_tx_tvalid,
   input wire logic              s_axis_tx_tready,
   input wire logic              cfg_to_turnoff,
   input wire logic              cfg_turnoff_ok
);
   // Every check runs on the core clock and rests in reset.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Last beat of a request or completion taken, and the quiet state.
   wire rx_end = m_axis_rx_tvalid && m_axis_rx_tready && m_axis_rx_tlast;
   wire tx_end = s_axis_tx_tvalid && s_axis_tx_tready && s_axis_tx_tlast;
   wire idle   = m_axis_rx_tready && !m_axis_rx_tvalid && !s_axis_tx_tvalid;

   a_rdy_after_end: assert property (rx_end |=> !m_axis_rx_tready)
      else $error("rx ready stayed high after a request end");
   a_reset_idle: assert property ($rose(resetn) |-> m_axis_rx_tready && !s_axis_tx_tvalid)
      else $error("not idle after reset release");
   a_no_rx_in_cpl: assert property (s_axis_tx_tvalid |-> !m_axis_rx_tready)
      else $error("rx ready high while a completion is pending");
   a_tx_beat_hold: assert property (s_axis_tx_tvalid && !s_axis_tx_tready |=>
      s_axis_tx_tvalid && $stable(s_axis_tx_tdata) && $stable(s_axis_tx_tlast))
      else $error("completion beat changed before it was taken");
   a_rdy_after_cpl: assert property (tx_end |-> ##[1:2] m_axis_rx_tready)
      else $error("rx ready late after completion sent");
   a_rdy_returns: assert property ($fell(m_axis_rx_tready) |-> ##[1:60] m_axis_rx_tready)
      else $error("rx ready did not return");
   a_off_ack: assert property (cfg_to_turnoff && idle |=> cfg_turnoff_ok)
      else $error("turn-off request not acknowledged");
   a_off_cause: assert property (cfg_turnoff_ok |-> $past(cfg_to_turnoff))
      else $error("turn-off ack without request");
   a_off_drop: assert property (!cfg_to_turnoff |=> !cfg_turnoff_ok)
      else $error("turn-off ack outlived request");

   c_rx_end: cover property (rx_end);
   c_tx_end: cover property (tx_end);
   c_tx_stall: cover property (s_axis_tx_tvalid && !s_axis_tx_tready);
   c_off_ok: cover property (cfg_turnoff_ok);
endmodule

bind ptr_target ptr_target_props #(.DATA_W(DATA_W)) i_props (
   .core_clk(core_clk), .resetn(resetn),
   .m_axis_rx_tvalid(m_axis_rx_tvalid), .m_axis_rx_tlast(m_axis_rx_tlast),
   .m_axis_rx_tready(m_axis_rx_tready), .s_axis_tx_tdata(s_axis_tx_tdata),
   .s_axis_tx_tlast(s_axis_tx_tlast), .s_axis_tx_tvalid(s_axis_tx_tvalid),
   .s_axis_tx_tready(s_axis_tx_tready), .cfg_to_turnoff(cfg_to_turnoff),
   .cfg_turnoff_ok(cfg_turnoff_ok)
);

/* dv/ptr_core_model.sv */
/*
 * Behavioural endpoint core facing the responder, 64-bit streams.
 * Assumes requests already matched a BAR; the bench sets the hit vector.
 */
`timescale 1ns/10ps
module ptr_core_model (
   input  wire logic        core_clk,
   output logic [63:0]      rx_tdata,
   output logic             rx_tlast,
   output logic             rx_tvalid,
   output logic [21:0]      rx_tuser,
   input  wire logic        rx_tready,
   input  wire logic [63:0] tx_tdata,
   input  wire logic [7:0]  tx_tkeep,
   input  wire logic        tx_tvalid,
   output logic             tx_tready
);
   logic [31:0] got[$];       // Completion words collected in order.
   logic        stall = 1'b0; // When set, take one beat in four.
   logic [1:0]  ph    = 2'h0; // Phase of the slow-accept pattern.

   // Quiet lines at time zero.
   initial begin
      rx_tdata  = 64'h0;
      rx_tlast  = 1'b0;
      rx_tvalid = 1'b0;
      rx_tuser  = 22'h0;
      tx_tready = 1'b1;
   end

   // Collect kept words of every beat taken, and pace the accept line.
   always @(posedge core_clk) begin
      if (tx_tvalid && tx_tready) begin
         for (int k = 0; k < 2; k++) begin
            if (tx_tkeep[4*k]) got.push_back(tx_tdata[32*k +: 32]);
         end
      end
      ph <= ph + 2'h1;
      tx_tready <= #1 !stall || (ph == 2'h0);
   end

   // Offer n words two per beat, each beat held until ready is seen.
   task automatic send(input logic [191:0] pk, input int n, input logic [7:0] hit);
      @(posedge core_clk);
      #1;
      for (int b = 0; b < (n + 1) / 2; b++) begin
         rx_tdata  = pk[64*b +: 64];
         rx_tuser  = {12'h000, hit, 2'h0};
         rx_tlast  = (b == (n + 1) / 2 - 1);
         rx_tvalid = 1'b1;
         do @(posedge core_clk); while (rx_tready !== 1'b1);
         #1;
      end
      rx_tvalid = 1'b0;
      rx_tlast  = 1'b0;
      rx_tdata  = ~rx_tdata; // Released data does not keep its value.
   endtask
endmodule

/* dv/testbench.sv */
/*
 * Self-checking bench for the target responder, 64-bit datapath.
 * Assumes ptr_core_model stands in for the endpoint core.
 */
`timescale 1ns/10ps
module testbench;
   logic        core_clk, resetn, off_req, off_ok, rx_tlast, rx_tvalid;
   logic        rx_tready, tx_tlast, tx_tvalid, tx_tready;
   logic [63:0] rx_tdata, tx_tdata;
   logic [21:0] rx_tuser;
   logic [7:0]  tx_tkeep;
   int          fail_count = 0, n_compared = 0, cycles = 0;
   localparam logic [31:0] RTAG = 32'h0101070F; // Requester, tag, byte enables.
   localparam logic [15:0] CID  = 16'h0200;     // Completer identity.

   ptr_target #(.DATA_W(64)) i_dut (
      .core_clk(core_clk), .resetn(resetn), .m_axis_rx_tdata(rx_tdata),
      .m_axis_rx_tkeep(8'hFF), .m_axis_rx_tlast(rx_tlast), .m_axis_rx_tvalid(rx_tvalid),
      .m_axis_rx_tuser(rx_tuser), .m_axis_rx_tready(rx_tready), .s_axis_tx_tdata(tx_tdata),
      .s_axis_tx_tkeep(tx_tkeep), .s_axis_tx_tlast(tx_tlast), .s_axis_tx_tvalid(tx_tvalid),
      .s_axis_tx_tready(tx_tready), .cfg_completer_id(CID), .cfg_to_turnoff(off_req),
      .cfg_turnoff_ok(off_ok));
   ptr_core_model i_core (
      .core_clk(core_clk), .rx_tdata(rx_tdata), .rx_tlast(rx_tlast), .rx_tvalid(rx_tvalid),
      .rx_tuser(rx_tuser), .rx_tready(rx_tready), .tx_tdata(tx_tdata), .tx_tkeep(tx_tkeep),
      .tx_tvalid(tx_tvalid), .tx_tready(tx_tready));

   // Free-running core clock.
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Cut a hang short.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   // Print the verdict and end the run.
   task automatic stop_test();
      if (fail_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compare one value and count it.
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      n_compared++;
      if (a !== e) begin
         $display("ERROR %0t: got %h expected %h", $time, a, e);
         fail_count++;
      end
   endtask

   // Build a request; four-word headers put the address in word 3.
   task automatic req(input logic [31:0] w0, input logic [7:0] hit, input logic [31:0] ad,
                      input logic [31:0] d, input int n);
      if (w0[29]) i_core.send({32'h0, d, ad, 32'h0, RTAG, w0}, n, hit);
      else i_core.send({32'h0, d, d, ad, RTAG, w0}, n, hit);
   endtask

   // Wait for one completion of n words and compare its words.
   task automatic cpl(input int n, input logic [31:0] w0, input logic [31:0] ad,
                      input logic [31:0] d);
      for (int t = 0; t < 200 && i_core.got.size() < n; t++) @(posedge core_clk);
      chk(32'(i_core.got.size() >= n), 32'h1);
      if (i_core.got.size() >= n) begin
         chk(i_core.got[0], w0);
         chk(i_core.got[1], {CID, 16'h0004});
         chk(i_core.got[2], {RTAG[31:8], 1'b0, ad[6:2], 2'b00});
         if (n == 4) chk(i_core.got[3], d);
         repeat (n) void'(i_core.got.pop_front());
      end
   endtask

   // Let traffic settle, then expect no stray completion words.
   task automatic quiet();
      repeat (30) @(posedge core_clk);
      #1 chk(32'(i_core.got.size()), 32'h0);
   endtask

   // Idle state straight after reset.
   task automatic t_reset();
      chk(32'(rx_tready), 32'h1);
      chk(32'(tx_tvalid), 32'h0);
      chk(32'(off_ok), 32'h0);
   endtask

   // Back-to-back writes to two regions, then back-to-back reads, slow accept.
   task automatic t_mem();
      req(32'h40000001, 8'h04, 32'h10, 32'h1234ABCD, 4);
      req(32'h60000001, 8'h02, 32'h10, 32'h0BADF00D, 5);
      quiet();
      i_core.stall = 1'b1;
      req(32'h00000001, 8'h04, 32'h10, 32'h0, 3);
      req(32'h20000001, 8'h02, 32'h10, 32'h0, 4);
      cpl(4, 32'h4A000001, 32'h10, 32'h1234ABCD);
      cpl(4, 32'h4A000001, 32'h10, 32'h0BADF00D);
      i_core.stall = 1'b0;
      quiet();
   endtask

   // Two-word write is taken whole, then dropped without effect.
   task automatic t_long();
      req(32'h40000002, 8'h04, 32'h10, 32'hFFFF0000, 5);
      quiet();
      req(32'h00000001, 8'h04, 32'h10, 32'h0, 3);
      cpl(4, 32'h4A000001, 32'h10, 32'h1234ABCD);
   endtask

   // I/O write gets a no-data completion; read back through bit 0.
   task automatic t_io();
      req(32'h42000001, 8'h01, 32'h20, 32'hCAFE0001, 4);
      cpl(3, 32'h0A000000, 32'h20, 32'h0);
      req(32'h02000001, 8'h01, 32'h20, 32'h0, 3);
      cpl(4, 32'h4A000001, 32'h20, 32'hCAFE0001);
      quiet();
   endtask

   // Turn-off request is acknowledged while held, released after.
   task automatic t_turnoff();
      @(posedge core_clk);
      #1 off_req = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(32'(off_ok), 32'h1);
      off_req = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk(32'(off_ok), 32'h0);
   endtask

   // Main sequence.
   initial begin
      resetn  = 1'b0;
      off_req = 1'b0;
      repeat (4) @(posedge core_clk);
      #1 resetn = 1'b1;
      t_reset();
      t_mem();
      t_long();
      t_io();
      t_turnoff();
      stop_test();
   end
endmodule
